// *** iws_dev.sv ***
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
// ==========================================================================
// ==========================================================================
// Wiper setting device: serial slave holding one 7-bit setting.
module iws_dev (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	iws_link_if.dev link,
	output logic [iws_pkg::SETTING_W-1:0] o_setting,
	output logic [iws_pkg::TAP_COUNT-1:0] o_tap
);
	import iws_pkg::*;

	// ======================================================================
	// State record.
	typedef struct packed {
		iws_dev_state_type st; // Protocol state.
		logic [7:0] shift; // Byte being received or sent.
		logic [3:0] bitcnt; // Clock pulses seen in this byte.
		logic rw; // Direction latched from the address byte.
		logic macked; // Master acknowledged the last read byte.
		logic [SETTING_W-1:0] setting; // The wiper setting.
		logic [TAP_COUNT-1:0] tap; // One-hot tap select.
		logic sda_oe; // Pull the data line low while high.
		logic sda_o; // Driven value; always zero for an open-drain line.
		logic scl_d; // Synchronised clock one cycle ago.
		logic sda_d; // Synchronised data one cycle ago.
	} iws_dev_regs_type;

	iws_dev_regs_type r;
	iws_dev_regs_type next_r;
	logic [1:0] line_sync; // Bit 1 is the clock, bit 0 the data.
	logic scl_s; // Synchronised clock level.
	logic sda_s; // Synchronised data level.
	logic scl_rise; // Clock went high this cycle.
	logic scl_fall; // Clock went low this cycle.
	logic start_seen; // Data fell while the clock stayed high.
	logic stop_seen; // Data rose while the clock stayed high.
	logic [TAP_COUNT-1:0] tap_dec; // Decoded tap for the present setting.

	// ======================================================================
	// Line synchronisers.
	// Both lines go through the same two stages so their relative timing,
	// which is what separates a START from a data bit, is kept.
	iws_sync #(.W(2)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_async({link.scl, link.sda}),
		.o_sync(line_sync)
	);

	assign scl_s = line_sync[1];
	assign sda_s = line_sync[0];

	// Edge and condition detection on the synchronised samples only.
	assign scl_rise = scl_s & ~r.scl_d;
	assign scl_fall = ~scl_s & r.scl_d;
	assign start_seen = scl_s & r.scl_d & r.sda_d & ~sda_s;
	assign stop_seen = scl_s & r.scl_d & ~r.sda_d & sda_s;

	// ======================================================================
	// Tap decoder: exactly one select is high, bit index equals the code,
	// so bit 0 is the bottom terminal end and bit 127 the top.
	genvar gi;
	generate
		for (gi = 0; gi < TAP_COUNT; gi++) begin : g_tap
			assign tap_dec[gi] = (r.setting == SETTING_W'(gi));
		end
	endgenerate

	// ======================================================================
	// Protocol engine.
	// The device only moves the data line right after it sees the clock
	// fall, so its own edges never look like START or STOP to anyone.
	always_comb begin
		next_r = r;
		next_r.scl_d = scl_s;
		next_r.sda_d = sda_s;
		next_r.sda_o = 1'b0;
		// The tap register trails the setting by one cycle.
		next_r.tap = tap_dec;
		if (stop_seen) begin
			// A STOP ends any transfer; a partial byte is dropped.
			next_r.st = DS_IDLE;
			next_r.sda_oe = 1'b0;
		end else if (start_seen) begin
			// A START, repeated or not, always expects a fresh address.
			next_r.st = DS_ADDR;
			next_r.bitcnt = 4'h0;
			next_r.sda_oe = 1'b0;
		end else begin
			case (r.st)
				DS_IDLE, DS_IGNORE: begin
					// Bus untouched until the next START.
					next_r.sda_oe = 1'b0;
				end
				DS_ADDR: begin
					if (scl_rise) begin
						// Data is taken on the rising clock edge.
						next_r.shift = {r.shift[6:0], sda_s};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
						if (r.shift[7:1] == DEV_ADDR) begin
							// Pull low through the ninth pulse.
							next_r.sda_oe = 1'b1;
							next_r.rw = r.shift[0];
							next_r.st = DS_ADDR_ACK;
						end else begin
							// Foreign address: stay off the bus.
							next_r.st = DS_IGNORE;
						end
					end
				end
				DS_ADDR_ACK: begin
					if (scl_fall) begin
						next_r.bitcnt = 4'h0;
						if (r.rw == DIR_READ) begin
							// Top bit of a read byte is always zero.
							next_r.shift = {1'b0, r.setting};
							next_r.sda_oe = 1'b1;
							next_r.st = DS_RDATA;
						end else begin
							next_r.sda_oe = 1'b0;
							next_r.st = DS_WDATA;
						end
					end
				end
				DS_WDATA: begin
					if (scl_rise) begin
						next_r.shift = {r.shift[6:0], sda_s};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
						// Only a whole byte changes the setting; top bit dropped.
						next_r.setting = r.shift[SET_MSB:0];
						next_r.sda_oe = 1'b1;
						next_r.st = DS_WACK;
					end
				end
				DS_WACK: begin
					if (scl_fall) begin
						// Release and wait for another data byte.
						next_r.sda_oe = 1'b0;
						next_r.bitcnt = 4'h0;
						next_r.st = DS_WDATA;
					end
				end
				DS_RDATA: begin
					if (scl_rise) begin
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (r.bitcnt == BYTE_BITS) begin
							// Ninth pulse belongs to the master.
							next_r.sda_oe = 1'b0;
							next_r.st = DS_RACK;
						end else begin
							// Next bit goes out while the clock is low.
							next_r.shift = {r.shift[6:0], 1'b0};
							next_r.sda_oe = ~r.shift[6];
						end
					end
				end
				DS_RACK: begin
					if (scl_rise) begin
						next_r.macked = ~sda_s;
					end else if (scl_fall) begin
						if (r.macked) begin
							// Master wants more: send the setting again.
							next_r.shift = {1'b0, r.setting};
							next_r.sda_oe = 1'b1;
							next_r.bitcnt = 4'h0;
							next_r.st = DS_RDATA;
						end else begin
							// No-acknowledge: hands the line back for STOP.
							next_r.st = DS_IGNORE;
						end
					end
				end
				default: begin
					next_r.st = DS_IDLE;
					next_r.sda_oe = 1'b0;
				end
			endcase
		end
		// Top bit of a read byte is zero, so the first bit is always low.
		if (r.st == DS_ADDR_ACK && scl_fall && r.rw == DIR_READ && !stop_seen
				&& !start_seen) begin
			next_r.sda_oe = ~(1'b0);
		end
	end

	// ======================================================================
	// State register. Reset stands in for power-on: midscale is loaded
	// before any write can arrive.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			r.st <= DS_IDLE;
			r.shift <= 8'h00;
			r.bitcnt <= 4'h0;
			r.rw <= DIR_WRITE;
			r.macked <= 1'b0;
			r.setting <= SETTING_RESET;
			r.tap <= {{(TAP_COUNT - 1){1'b0}}, 1'b1} << SETTING_RESET;
			r.sda_oe <= 1'b0;
			r.sda_o <= 1'b0;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ======================================================================
	// Outputs, all straight from the state record.
	assign o_setting = r.setting;
	assign o_tap = r.tap;
	assign link.d_sda_oe = r.sda_oe;
	assign link.d_sda_o = r.sda_o;
endmodule

// *** iws_pkg.sv ***
// ==========================================================================
// Shared constants for the wiper setting link.
package iws_pkg;
	// ======================================================================
	// Bus address and setting layout.
	localparam logic [6:0] DEV_ADDR = 7'h2e; // Fixed 7-bit bus address 0101110.
	localparam int SETTING_W = 7; // Width of the wiper setting.
	localparam int TAP_COUNT = 128; // Number of tap-select outputs.
	localparam logic [6:0] SETTING_RESET = 7'h40; // Midscale code, decimal 64.
	localparam logic [3:0] BYTE_BITS = 4'h8; // Data bits in one byte.
	localparam int SET_MSB = 6; // Top bit of the setting in a data byte.
	localparam int DATA_TOP = 7; // Top bit of a byte, sent as zero on reads.
	localparam logic DIR_WRITE = 1'b0; // Direction bit for a master write.
	localparam logic DIR_READ = 1'b1; // Direction bit for a master read.

	// ======================================================================
	// Serial clock timing made by the controller.
	localparam int CLK_PERIOD_NS = 10; // Local clock period.
	localparam int SCL_QTR_NS = 625; // Quarter of a 2500 ns serial clock period.
	localparam logic [11:0] SCL_QTR_CYC = 12'((SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ======================================================================
	// Controller register map on the Wishbone bus (byte addresses).
	localparam logic [3:0] REG_CTRL = 4'h0; // Command: go, direction, byte count.
	localparam logic [3:0] REG_WDATA = 4'h4; // Setting to be written.
	localparam logic [3:0] REG_STATUS = 4'h8; // Busy, no-acknowledge, read data.
	localparam int CTRL_GO_BIT = 0; // Write one to start a transfer.
	localparam int CTRL_READ_BIT = 1; // One for a read transfer.
	localparam int CTRL_CNT_LSB = 8; // Data byte count, four bits.
	localparam int STAT_BUSY_BIT = 0; // Transfer in progress.
	localparam int STAT_NACK_BIT = 1; // Last transfer saw a no-acknowledge.
	localparam int STAT_RDATA_LSB = 8; // Last setting read back, seven bits.

	// ======================================================================
	// State encodings.
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_ADDR = 3'h1,
		DS_ADDR_ACK = 3'h2,
		DS_WDATA = 3'h3,
		DS_WACK = 3'h4,
		DS_RDATA = 3'h5,
		DS_RACK = 3'h6,
		DS_IGNORE = 3'h7
	} iws_dev_state_type;

	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_START = 2'h1,
		HS_BIT = 2'h2,
		HS_STOP = 2'h3
	} iws_host_state_type;
endpackage

// *** iws_link_if.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Two-wire link between controller and wiper setting device.
interface iws_link_if;
	logic scl; // Serial clock, driven by the controller.
	logic h_sda_o; // Controller data output value.
	logic h_sda_oe; // Controller drives the data line while high.
	logic d_sda_o; // Device data output value.
	logic d_sda_oe; // Device drives the data line while high.
	logic sda; // Resolved level of the shared data line.

	// The line is pulled up; any party driving a zero pulls it low.
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

	modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

// *** iws_sync.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Two-flop synchroniser for asynchronous pin levels.
module iws_sync #(
	parameter int W = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	import iws_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta; // First stage, read only by the second.
		logic [W-1:0] safe; // Second stage, safe for logic.
	} iws_sync_regs_type;

	iws_sync_regs_type r;
	iws_sync_regs_type next_r;

	// Shift the pin levels through both stages.
	always_comb begin
		next_r.meta = i_async;
		next_r.safe = r.meta;
	end

	// Idle bus lines are high, so reset to ones.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign o_sync = r.safe;
endmodule

// *** iws_host.sv ***
`timescale 1ns/1ns
// ==========================================================================
// Bus controller: Wishbone registers in, two-wire transfers out.
module iws_host #(
	parameter logic [11:0] QTR_CYC = iws_pkg::SCL_QTR_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	iws_link_if.host link
);
	import iws_pkg::*;

	// ======================================================================
	// State record.
	typedef struct packed {
		iws_host_state_type st; // Transfer state.
		logic [11:0] div; // Quarter-period divider.
		logic [1:0] ph; // Quarter within the clock period.
		logic [3:0] bitn; // Bit of the byte, 8 is the acknowledge.
		logic [3:0] left; // Data bytes still to move.
		logic [7:0] shift; // Byte being sent or received.
		logic first; // Address byte in flight.
		logic rd; // Read transfer.
		logic nack; // No-acknowledge seen.
		logic [SETTING_W-1:0] wdata; // Setting to write.
		logic [SETTING_W-1:0] rdata; // Last setting read.
		logic scl; // Serial clock output.
		logic sda_oe; // Pull data low while high.
		logic [31:0] dat; // Wishbone read data.
		logic ack; // Wishbone acknowledge.
	} iws_host_regs_type;

	iws_host_regs_type r;
	iws_host_regs_type next_r;
	logic sda_s; // Synchronised data line.
	logic tick; // One quarter period has passed.
	logic wr_req; // Wishbone write taken this cycle.
	logic busy; // A transfer is running.
	logic tx; // The controller sends the current byte.

	iws_sync #(.W(1)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_async(link.sda),
		.o_sync(sda_s)
	);

	assign tick = (r.div == 12'h000);
	assign wr_req = i_wb_cyc & i_wb_stb & i_wb_we & ~r.ack;
	assign busy = (r.st != HS_IDLE);
	assign tx = r.first | ~r.rd;

	// ======================================================================
	// Register slave and transfer engine. Every bus access is answered one
	// cycle after the strobe; unmapped reads return zero, writes to them
	// are dropped. A go while busy is ignored.
	always_comb begin
		next_r = r;
		next_r.ack = i_wb_cyc & i_wb_stb & ~r.ack;
		next_r.dat = 32'h0000_0000;
		if (i_wb_adr == REG_STATUS) begin
			next_r.dat[STAT_BUSY_BIT] = busy;
			next_r.dat[STAT_NACK_BIT] = r.nack;
			next_r.dat[STAT_RDATA_LSB +: SETTING_W] = r.rdata;
		end else if (i_wb_adr == REG_WDATA) begin
			next_r.dat[SETTING_W-1:0] = r.wdata;
		end
		if (wr_req && i_wb_adr == REG_WDATA && i_wb_sel[0]) begin
			next_r.wdata = i_wb_dat[SETTING_W-1:0];
		end
		next_r.div = tick ? (QTR_CYC - 12'h001) : (r.div - 12'h001);
		case (r.st)
			HS_IDLE: begin
				next_r.scl = 1'b1;
				next_r.sda_oe = 1'b0;
				if (wr_req && i_wb_adr == REG_CTRL && i_wb_sel[0] && i_wb_sel[1]
						&& i_wb_dat[CTRL_GO_BIT]) begin
					next_r.rd = i_wb_dat[CTRL_READ_BIT];
					next_r.shift = {DEV_ADDR, i_wb_dat[CTRL_READ_BIT]};
					next_r.left = (i_wb_dat[CTRL_CNT_LSB +: 4] == 4'h0) ? 4'h1
						: i_wb_dat[CTRL_CNT_LSB +: 4];
					next_r.first = 1'b1;
					next_r.nack = 1'b0;
					next_r.ph = 2'h0;
					next_r.div = QTR_CYC - 12'h001;
					next_r.st = HS_START;
				end
			end
			HS_START: begin
				if (tick) begin
					next_r.ph = r.ph + 2'h1;
					if (r.ph == 2'h0) begin
						next_r.sda_oe = 1'b1;
					end else if (r.ph == 2'h1) begin
						next_r.scl = 1'b0;
						next_r.ph = 2'h0;
						next_r.bitn = 4'h0;
						next_r.st = HS_BIT;
					end
				end
			end
			HS_BIT: begin
				if (tick) begin
					next_r.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							// Data moves only in the low half of the clock.
							if (r.bitn != BYTE_BITS) begin
								next_r.sda_oe = tx & ~r.shift[DATA_TOP];
							end else begin
								// Read ack low for more, high on the last byte.
								next_r.sda_oe = ~tx & (r.left != 4'h1);
							end
						end
						2'h1: next_r.scl = 1'b1;
						2'h2: begin
							if (r.bitn != BYTE_BITS) begin
								next_r.shift = {r.shift[6:0], sda_s};
							end else if (tx && sda_s) begin
								next_r.nack = 1'b1;
							end
						end
						default: begin
							next_r.scl = 1'b0;
							next_r.bitn = r.bitn + 4'h1;
							if (r.bitn == BYTE_BITS) begin
								next_r.bitn = 4'h0;
								next_r.shift = {1'b0, r.wdata};
								if (!r.first && r.rd) begin
									next_r.rdata = r.shift[SET_MSB:0];
								end
								if (!r.first) begin
									next_r.left = r.left - 4'h1;
								end
								next_r.first = 1'b0;
								if (r.nack || (!r.first && r.left == 4'h1)) begin
									next_r.st = HS_STOP;
								end
							end
						end
					endcase
				end
			end
			default: begin
				if (tick) begin
					next_r.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: next_r.sda_oe = 1'b1;
						2'h1: next_r.scl = 1'b1;
						2'h2: next_r.sda_oe = 1'b0;
						default: next_r.st = HS_IDLE;
					endcase
				end
			end
		endcase
	end

	// ======================================================================
	// State register.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			r <= '0;
			r.st <= HS_IDLE;
			r.scl <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign o_wb_dat = r.dat;
	assign o_wb_ack = r.ack;
	assign link.scl = r.scl;
	assign link.h_sda_oe = r.sda_oe;
	assign link.h_sda_o = 1'b0;
endmodule

// *** iws_link_monitor.sv ***
`timescale 1ns/1ns
// ======================================================================
// Checker beside the link that joins controller and device.
module iws_link_monitor (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_oe,
	input wire logic [iws_pkg::SETTING_W-1:0] o_setting,
	input wire logic [iws_pkg::TAP_COUNT-1:0] o_tap
);
	import iws_pkg::*;
	logic past_scl; // Line levels one clock back.
	logic past_sda;
	logic start_seen; // Data falls while the clock stays high.
	logic stop_seen; // Data rises while the clock stays high.

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	// ======================================================================
	// Idle lines read high, so reset the history high to avoid false conditions.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			past_scl <= 1'b1;
			past_sda <= 1'b1;
		end else begin
			past_scl <= scl;
			past_sda <= sda;
		end
	end
	assign start_seen = scl & past_scl & past_sda & ~sda;
	assign stop_seen = scl & past_scl & ~past_sda & sda;

	// ======================================================================
	// Assertions.
	a_tap_one_hot: assert property ($onehot(o_tap))
		else $error("tap select is not one-hot");
	a_tap_follows_code: assert property (o_tap == (TAP_COUNT'(1) << $past(o_setting)))
		else $error("tap select does not match setting");
	a_setting_power_on: assert property (@(posedge i_ref_clk) disable iff (1'b0)
		!i_nrst |=> o_setting == SETTING_RESET) else $error("setting not midscale after reset");
	a_ack_rise_low: assert property ($rose(d_sda_oe) |-> !scl)
		else $error("device pulled data while clock high");
	a_ack_fall_low: assert property ($fell(d_sda_oe) |-> !scl)
		else $error("device released data while clock high");
	a_setting_clock_low: assert property ($changed(o_setting) |-> !scl)
		else $error("setting changed while clock high");
	a_start_quiet: assert property (start_seen |-> (!d_sda_oe) [*4])
		else $error("device drives data around a start");
	a_stop_quiet: assert property (stop_seen |=> (!d_sda_oe && $stable(o_setting)) [*4])
		else $error("device active after a stop");

	// A few scenarios that the run must reach.
	c_ack: cover property ($rose(d_sda_oe));
	c_update: cover property ($changed(o_setting));
	c_start: cover property (start_seen);
endmodule

// *** i2c_wiper_setting_slave_test.sv ***
`timescale 1ns/1ns
// ======================================================================
// Bench: controller and device face each other; a second device is bit-banged.
module i2c_wiper_setting_slave_test;
	import iws_pkg::*;
	logic i_ref_clk, i_nrst, wb_cyc, wb_stb, wb_we, wb_ack, b;
	logic [3:0] wb_adr, wb_sel, n;
	logic [31:0] wb_wdat, wb_rdat, wb_q;
	logic [7:0] v;
	logic [8:0] got; // Nine sampled line levels of one byte.
	logic [SETTING_W-1:0] setting, setting_b;
	logic [TAP_COUNT-1:0] tap;
	int n_mismatch = 0;
	int tests_run = 0;
	iws_link_if link();
	iws_link_if link_b(); // Second link, driven by the bench to break the rules.

	// A small quarter count keeps runs short; the device needs four clocks.
	iws_host #(.QTR_CYC(12'h8)) u_iws_host (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
		.i_wb_dat(wb_wdat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
		.link(link.host));
	iws_dev u_iws_dev (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link.dev),
		.o_setting(setting), .o_tap(tap));
	iws_dev u_iws_dev_b (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link(link_b.dev),
		.o_setting(setting_b), .o_tap());
	iws_link_monitor u_iws_link_monitor (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.scl(link.scl), .sda(link.sda), .d_sda_oe(link.d_sda_oe),
		.o_setting(setting), .o_tap(tap));

	// ======================================================================
	// Clock and shared tasks.
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task check(input logic [127:0] seen, input logic [127:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Expected setting for a data byte: the top bit is dropped.
	function automatic logic [SETTING_W-1:0] exp_set(input logic [7:0] code);
		exp_set = code[SET_MSB:0];
	endfunction

	// Expected tap select for a data byte: one bit, at the index of the code.
	function automatic logic [TAP_COUNT-1:0] exp_tap(input logic [7:0] code);
		exp_tap = TAP_COUNT'(1) << code[SET_MSB:0];
	endfunction

	task conclude;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One classic Wishbone cycle; the answer is taken at the edge that sees ack.
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge i_ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= 4'hf;
		i = 0;
		do begin
			@(posedge i_ref_clk);
			i++;
		end while (wb_ack !== 1'b1 && i < 100);
		wb_q = wb_rdat;
		// A bus that never answers ends the run with a failure.
		if (wb_ack !== 1'b1) begin
			check(wb_ack, 1'b1);
			conclude;
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// Polls the status until busy clears, bounded.
	task wait_idle;
		for (int i = 0; i < 3000; i++) begin
			wb(1'b0, REG_STATUS, 32'h0);
			if (wb_q[STAT_BUSY_BIT] === 1'b0) break;
		end
		check(wb_q[STAT_BUSY_BIT], 1'b0);
		// A transfer that never ends goes straight to the report.
		if (wb_q[STAT_BUSY_BIT] !== 1'b0) begin
			conclude;
		end
	endtask

	// ======================================================================
	// Bench-driven link: one bit is 16 clocks, a 160 ns link clock.
	task lb_bit(input logic bit_v, output logic seen);
		@(posedge i_ref_clk);
		link_b.h_sda_oe <= ~bit_v;
		repeat (4) @(posedge i_ref_clk);
		link_b.scl <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		seen = link_b.sda;
		repeat (4) @(posedge i_ref_clk);
		link_b.scl <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask

	task lb_byte(input logic [7:0] d, input logic ab, output logic [8:0] g);
		for (int i = 0; i < 9; i++) lb_bit((i < 8) ? d[7-i] : ab, g[8-i]);
	endtask

	task lb_start;
		@(posedge i_ref_clk);
		link_b.h_sda_oe <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		link_b.scl <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		link_b.h_sda_oe <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		link_b.scl <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask

	task lb_stop;
		@(posedge i_ref_clk);
		link_b.h_sda_oe <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		link_b.scl <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		link_b.h_sda_oe <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
	endtask

	// ======================================================================
	// Main sequence.
	initial begin
		{wb_cyc, wb_stb, wb_we, i_nrst} = 4'h0;
		wb_adr = 4'h0;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		link_b.scl = 1'b1;
		link_b.h_sda_oe = 1'b0;
		link_b.h_sda_o = 1'b0;
		void'($urandom(32'hb60a));
		repeat (12) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		check(setting, SETTING_RESET);
		check(tap, exp_tap({1'b0, SETTING_RESET}));
		// Corner codes first, then random ones, with one or two data bytes.
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
			n = 4'($urandom % 3);
			wb(1'b1, REG_WDATA, {24'h0, v});
			wb(1'b1, REG_CTRL, {20'h0, n, 8'h01});
			wait_idle;
			check(wb_q[STAT_NACK_BIT], 1'b0);
			check(setting, exp_set(v));
			check(tap, exp_tap(v));
			wb(1'b1, REG_CTRL, {20'h0, n, 8'h03});
			wait_idle;
			check(wb_q[STAT_NACK_BIT], 1'b0);
			check(wb_q[STAT_RDATA_LSB+6:STAT_RDATA_LSB], exp_set(v));
			// The staged setting reads back unchanged.
			wb(1'b0, REG_WDATA, 32'h0);
			check(wb_q, {25'h0, exp_set(v)});
		end
		wb(1'b0, 4'hc, 32'h0);
		check(wb_q, 32'h0); // Unmapped address reads zero.
		// A foreign address is left unanswered.
		lb_start;
		lb_byte({DEV_ADDR ^ 7'h01, DIR_WRITE}, 1'b1, got);
		check(got[0], 1'b1);
		lb_stop;
		// A start in mid-byte abandons the write.
		lb_start;
		lb_byte({DEV_ADDR, DIR_WRITE}, 1'b1, got);
		check(got[0], 1'b0);
		for (int i = 0; i < 4; i++) lb_bit(1'b1, b);
		lb_start;
		check(setting_b, SETTING_RESET);
		lb_byte({DEV_ADDR, DIR_WRITE}, 1'b1, got);
		lb_byte(8'h85, 1'b1, got);
		check(got[0], 1'b0);
		lb_stop;
		check(setting_b, exp_set(8'h85));
		// Read twice; the top bit must come back as zero.
		lb_start;
		lb_byte({DEV_ADDR, DIR_READ}, 1'b1, got);
		check(got[0], 1'b0);
		lb_byte(8'hff, 1'b0, got);
		check(got[8:1], {1'b0, exp_set(8'h85)});
		lb_byte(8'hff, 1'b1, got);
		check(got[8:1], {1'b0, exp_set(8'h85)});
		lb_stop;
		conclude;
	end

	// A hang counts as a mismatch.
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		n_mismatch++;
		conclude;
	end
endmodule
